// [core/optical_sensor_pkg.sv]
// shared constants for the optical sensor serial register port
package optical_sensor_pkg;
  // ===================================================
  // bus addressing
  localparam logic [6:0] SLAVE_ADDR = 7'h5E;
  localparam logic [7:0] WRITE_ADDR_BYTE = 8'hBC;
  localparam logic [7:0] READ_ADDR_BYTE = 8'hBD;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SLOT_DONE = 4'h9;
  localparam int SCL_MAX_KHZ = 400;
  // ===================================================
  // register offsets
  localparam logic [7:0] INT_STATUS_ADDR = 8'h00;
  localparam logic [7:0] SAMPLE_QUEUE_ADDR = 8'h07;
  localparam logic [7:0] LED_RANGE_ADDR = 8'h14;
  localparam logic [7:0] PROX_AMP_ADDR = 8'h15;
  localparam logic [7:0] DEVICE_ID_ADDR = 8'hFF;
  // ===================================================
  // field layout and reset values
  localparam int PWR_RDY_BIT = 7;
  localparam int IR_RANGE_LSB = 0;
  localparam int GREEN_RANGE_LSB = 4;
  localparam logic [7:0] PROX_AMP_RESET = 8'h00;
  localparam logic [1:0] RANGE_RESET = 2'h0;
  localparam logic [7:0] FULL_SCALE_STEP_MA = 8'h32;
endpackage

// [core/link_events_if.sv]
// sampled sda level, scl edges and bus events
`timescale 1ns/1ns
interface link_events_if;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport src (output sda, output scl_rise, output scl_fall, output start, output stop);
  modport dst (input sda, input scl_rise, input scl_fall, input start, input stop);
endinterface

// [core/line_sync.sv]
// synchronises scl and sda and finds edges, start and stop
`timescale 1ns/1ns
module line_sync (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda_in,
  link_events_if.src ev
);
  logic [2:0] scl_q;
  logic [2:0] sda_q;

  // ===================================================
  // two-flop sync plus one history stage
  // R15: scl is only sampled, never driven
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end
    else
    begin
      scl_q <= {scl_q[1:0], scl};
      sda_q <= {sda_q[1:0], sda_in};
    end
  end

  // ===================================================
  // events, read only from the stages past the first
  assign ev.sda = sda_q[1];
  assign ev.scl_rise = scl_q[1] & ~scl_q[2];
  assign ev.scl_fall = ~scl_q[1] & scl_q[2];
  // R5: start and stop
  assign ev.start = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign ev.stop = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
endmodule

// [core/led_drive_calc.sv]
// pilot led current and ir full scale from the amplitude and ranges
`timescale 1ns/1ns
module led_drive_calc (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] amplitude,
  input wire logic [1:0] ir_led_current_range,
  input wire logic [1:0] green_range,
  input wire logic use_green,
  output logic [9:0] pilot_current_q,
  output logic [7:0] ir_full_scale_ma_q
);
  import optical_sensor_pkg::*;

  logic [1:0] selected_led_current_range;

  // range code plus one is the multiplier of both tables
  function automatic logic [2:0] range_mult(input logic [1:0] r);
    range_mult = {1'b0, r} + 3'h1;
  endfunction

  // R19: range of the led in use
  assign selected_led_current_range = use_green ? green_range : ir_led_current_range;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pilot_current_q <= 10'h000;
      ir_full_scale_ma_q <= 8'h00;
    end
    else
    begin
      // R20: units of 0.2 ma per code step
      pilot_current_q <= {2'h0, amplitude} * {7'h00, range_mult(selected_led_current_range)};
      // R21: 50 ma per range step
      ir_full_scale_ma_q <= 8'(FULL_SCALE_STEP_MA * range_mult(ir_led_current_range));
    end
  end
endmodule

// [core/optical_sensor_i2c_register_slave.sv]
// two-wire slave port and register bank of the optical sensor
//
// Behaviour
// R1: answer only to address 1011110, msb first
// R2: address lsb picks write or read
// R3: acknowledge matching address byte by pulling low
// R4: bitwise address compare, mismatch ignores until start
// R5: start and stop seen while scl high
// R6: one bit per scl cycle, stable high
// R7: stop aborts transfer, unless in start pulse
// R8: master never stops in start's high pulse
// R9: hold sda low through ninth pulse
// R10: master acks reads, last gets nack, stop
// R11: master retries when acknowledge is missing
// R12: write: address, register, data bytes, stop
// R13: write pointer advances after each data byte
// R14: eight bits plus one acknowledge pulse
// R15: master alone drives scl, up to 400khz
// R16: sda open drain only, never driven high
// R17: repeated start keeps session, awaits address
// R18: ready interrupt after power-up, cleared by read
// R19: pilot amplitude scaled by selected led range
// R20: pilot step 0.2 to 0.8 ma
// R21: ir range gives 50 to 200 ma
// R22: read-only identifier, writes ignored
// R23: master sets pointer, repeated start, reads
// R24: read pointer increments except at sample queue
// R25: unmapped reads zero, writes ignored, pointer advances
`timescale 1ns/1ns
module optical_sensor_i2c_register_slave #(
  // arbitrary neutral identifier value
  parameter logic [7:0] DEVICE_ID_VALUE = 8'h5A
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic int_n,
  input wire logic [7:0] sample_byte,
  output logic sample_pop,
  input wire logic pilot_use_green,
  output logic [7:0] proximity_led_amplitude,
  output logic [1:0] ir_led_current_range,
  output logic [9:0] pilot_current,
  output logic [7:0] ir_full_scale_ma
);
  import optical_sensor_pkg::*;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_REG = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_IGNORE = 3'b101
  } port_state_t;
  link_events_if ev ();
  port_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_q, tx_q, ptr_q;
  logic read_q, master_ack_q, start_high_q, drive_low_q, pwr_rdy_q, pwr_done_q;
  logic [7:0] amp_q;
  logic [1:0] ir_range_q, green_range_q;
  logic sda_out_q, sda_oe_n_q, int_n_q, pop_q;
  logic abort, byte_end, ack_end, wr_fire, ld_fire;
  logic [7:0] rd_data;

  // ===================================================
  // line sampling and led current
  line_sync u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .scl(scl),
    .sda_in(sda_in),
    .ev(ev.src)
  );
  led_drive_calc u_calc (
    .ref_clk(ref_clk),
    .reset(reset),
    .amplitude(amp_q),
    .ir_led_current_range(ir_range_q),
    .green_range(green_range_q),
    .use_green(pilot_use_green),
    .pilot_current_q(pilot_current),
    .ir_full_scale_ma_q(ir_full_scale_ma)
  );

  // ===================================================
  // register read decode
  function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic pwr,
    input logic [7:0] amp, input logic [1:0] ir_r, input logic [1:0] gr_r,
    input logic [7:0] smp, input logic [7:0] id);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      INT_STATUS_ADDR: v[PWR_RDY_BIT] = pwr;
      SAMPLE_QUEUE_ADDR: v = smp;
      LED_RANGE_ADDR:
      begin
        v[IR_RANGE_LSB +: 2] = ir_r;
        v[GREEN_RANGE_LSB +: 2] = gr_r;
      end
      PROX_AMP_ADDR: v = amp;
      // R22: fixed identifier
      DEVICE_ID_ADDR: v = id;
      // R25: unmapped reads as zero
      default: v = 8'h00;
    endcase
    reg_read = v;
  endfunction
  assign rd_data = reg_read(ptr_q, pwr_rdy_q, amp_q, ir_range_q, green_range_q,
                            sample_byte, DEVICE_ID_VALUE);
  // ===================================================
  // transfer decode
  // R7: stop in the start's own high pulse does not abort
  assign abort = ev.stop & ~start_high_q;
  // R14: eight data bits, then the acknowledge pulse
  assign byte_end = ev.scl_fall & (bit_cnt_q == BITS_PER_BYTE);
  assign ack_end = ev.scl_fall & (bit_cnt_q == ACK_SLOT_DONE);
  assign wr_fire = ~ev.start & ~abort & byte_end & (state_q == ST_WDATA);
  assign ld_fire = ~ev.start & ~abort & ack_end &
                   (((state_q == ST_ADDR) & read_q) |
                    ((state_q == ST_RDATA) & master_ack_q));

  // ===================================================
  // start marker within one scl high pulse
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      start_high_q <= 1'b0;
    else if (ev.start)
      start_high_q <= 1'b1;
    else if (ev.scl_fall)
      start_high_q <= 1'b0;
  end

  // ===================================================
  // protocol state and bit counter
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
    end
    // R17: any start, repeated or not, awaits an address
    else if (ev.start)
    begin
      state_q <= ST_ADDR;
      bit_cnt_q <= 4'h0;
    end
    // R7: stop ends the session
    else if (abort)
    begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
    end
    // R4: ignoring scl until next start
    else if (state_q == ST_IDLE || state_q == ST_IGNORE)
      bit_cnt_q <= 4'h0;
    else if (ev.scl_rise)
    begin
      // R6: one bit per scl cycle
      if (bit_cnt_q != ACK_SLOT_DONE)
        bit_cnt_q <= bit_cnt_q + 4'h1;
      // R1: compare one address bit per rise
      if (state_q == ST_ADDR && bit_cnt_q < BITS_PER_BYTE - 4'h1 &&
          ev.sda != SLAVE_ADDR[3'(BITS_PER_BYTE - 4'h2 - bit_cnt_q)])
        state_q <= ST_IGNORE;
      // R10: master nack ends the read
      if (state_q == ST_RDATA && bit_cnt_q == BITS_PER_BYTE && ev.sda)
        state_q <= ST_IGNORE;
    end
    else if (ack_end)
    begin
      bit_cnt_q <= 4'h0;
      case (state_q)
        // R2: direction from address lsb
        ST_ADDR: state_q <= read_q ? ST_RDATA : ST_REG;
        ST_REG: state_q <= ST_WDATA;
        default: state_q <= state_q;
      endcase
    end
  end

  // ===================================================
  // shift register and direction
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rx_q <= 8'h00;
      read_q <= 1'b0;
      master_ack_q <= 1'b0;
    end
    else if (ev.scl_rise)
    begin
      if (bit_cnt_q < BITS_PER_BYTE)
        rx_q <= {rx_q[6:0], ev.sda};
      // R2: last address bit is read or write
      if (state_q == ST_ADDR && bit_cnt_q == BITS_PER_BYTE - 4'h1)
        read_q <= ev.sda;
      if (bit_cnt_q == BITS_PER_BYTE)
        master_ack_q <= ~ev.sda;
    end
  end

  // ===================================================
  // register pointer
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      ptr_q <= 8'h00;
    else if (~ev.start & ~abort & byte_end & (state_q == ST_REG))
      ptr_q <= rx_q;
    // R13: advance after each written byte
    else if (wr_fire)
      ptr_q <= ptr_q + 8'h01;
    // R24: the sample queue address holds the pointer
    else if (ld_fire && ptr_q != SAMPLE_QUEUE_ADDR)
      ptr_q <= ptr_q + 8'h01;
  end

  // ===================================================
  // writable registers
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      amp_q <= PROX_AMP_RESET;
      ir_range_q <= RANGE_RESET;
      green_range_q <= RANGE_RESET;
    end
    else if (wr_fire)
    begin
      // R25: other addresses, identifier included, drop the write
      case (ptr_q)
        // R19: pilot amplitude
        PROX_AMP_ADDR: amp_q <= rx_q;
        // R21: led range fields
        LED_RANGE_ADDR:
        begin
          ir_range_q <= rx_q[IR_RANGE_LSB +: 2];
          green_range_q <= rx_q[GREEN_RANGE_LSB +: 2];
        end
        default: amp_q <= amp_q;
      endcase
    end
  end

  // ===================================================
  // transmit byte and sample queue pop
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      tx_q <= 8'h00;
      pop_q <= 1'b0;
    end
    else
    begin
      pop_q <= ld_fire & (ptr_q == SAMPLE_QUEUE_ADDR);
      // R23: data starts from the pointer set by the write
      if (ld_fire)
        tx_q <= rd_data;
      else if (ev.scl_fall && state_q == ST_RDATA && bit_cnt_q != 4'h0 &&
               bit_cnt_q < BITS_PER_BYTE)
        tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // ===================================================
  // sda open-drain driver, changes only while scl low
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      drive_low_q <= 1'b0;
    else if (ev.start || abort)
      drive_low_q <= 1'b0;
    else if (byte_end)
      // R3: address ack; R9: data ack held through ninth pulse
      drive_low_q <= state_q == ST_ADDR || state_q == ST_REG || state_q == ST_WDATA;
    else if (ld_fire)
      drive_low_q <= ~rd_data[7];
    else if (ack_end)
      drive_low_q <= 1'b0;
    else if (ev.scl_fall && state_q == ST_RDATA && bit_cnt_q != 4'h0 &&
             bit_cnt_q < BITS_PER_BYTE)
      drive_low_q <= ~tx_q[6];
    else if (state_q == ST_IGNORE || state_q == ST_IDLE)
      drive_low_q <= 1'b0;
  end

  // ===================================================
  // power-up ready flag; set once, so no clear can race it
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pwr_rdy_q <= 1'b0;
      pwr_done_q <= 1'b0;
    end
    // R18: raise once after reset release
    else if (!pwr_done_q)
    begin
      pwr_rdy_q <= 1'b1;
      pwr_done_q <= 1'b1;
    end
    // R18: reading status clears it
    else if (ld_fire && ptr_q == INT_STATUS_ADDR)
      pwr_rdy_q <= 1'b0;
  end
  // ===================================================
  // output flops
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      sda_out_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      int_n_q <= 1'b1;
    end
    else
    begin
      // R16: the data pin only ever pulls low
      sda_out_q <= 1'b0;
      sda_oe_n_q <= ~drive_low_q;
      int_n_q <= ~pwr_rdy_q;
    end
  end
  assign sda_out = sda_out_q;
  assign sda_oe_n = sda_oe_n_q;
  assign int_n = int_n_q;
  assign sample_pop = pop_q;
  assign proximity_led_amplitude = amp_q;
  assign ir_led_current_range = ir_range_q;
endmodule

// [testbench/optical_sensor_checker.sv]
// pin-level checks for the serial register port
`timescale 1ns/1ns
module optical_sensor_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic int_n,
  input wire logic sample_pop,
  input wire logic pilot_use_green,
  input wire logic [7:0] proximity_led_amplitude,
  input wire logic [1:0] ir_led_current_range,
  input wire logic [9:0] pilot_current,
  input wire logic [7:0] ir_full_scale_ma
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // ====================
  // line and interrupt
  a_drive_low_only: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  a_idle_released: assert property (disable iff (1'b0) reset |=> sda_oe_n && int_n)
    else $error("lines not released in reset");
  // a pull lasts past the high phase, not a glitch
  a_pull_held: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*6])
    else $error("pull released early");
  a_stable_high: assert property (scl && $past(scl) |-> $stable(sda_oe_n))
    else $error("sda changed while scl high");
  a_ready_int: assert property ($fell(reset) |-> ##[0:3] !int_n)
    else $error("ready interrupt missing");
  a_pop_single: assert property (sample_pop |-> !scl ##1 !sample_pop)
    else $error("sample pop malformed");
  // ====================
  // led drive
  a_ir_scale: assert property (!$past(reset) |->
      ir_full_scale_ma == 8'h32 * ({6'h0, $past(ir_led_current_range)} + 8'h01))
    else $error("ir full scale wrong");
  a_pilot_scale: assert property (!$past(reset) && !$past(pilot_use_green) |->
      pilot_current == {2'h0, $past(proximity_led_amplitude)} *
      ({8'h0, $past(ir_led_current_range)} + 10'h001))
    else $error("pilot current wrong");
endmodule
bind optical_sensor_i2c_register_slave optical_sensor_checker chk_u (
  .ref_clk(ref_clk), .reset(reset), .scl(scl), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .int_n(int_n), .sample_pop(sample_pop), .pilot_use_green(pilot_use_green),
  .proximity_led_amplitude(proximity_led_amplitude),
  .ir_led_current_range(ir_led_current_range), .pilot_current(pilot_current),
  .ir_full_scale_ma(ir_full_scale_ma)
);

// [testbench/bus_master_model.sv]
// host bus master model: drives scl, pulls sda low or lets it go
`timescale 1ns/1ns
module bus_master_model (
  input wire logic ref_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // ====================
  // start, never a stop in the same pulse
  task automatic start();
    tick(5);
    sda_pull = 1'b0;
    tick(1);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(5);
    sda_pull = 1'b1;
    tick(1);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b0;
    tick(8);
  endtask
  // sda moves only in the low phase, 32 ns period
  // sampled at the end of high, where the device pull has settled
  task automatic bit_slot(input logic b, output logic s);
    tick(5);
    sda_pull = ~b;
    tick(1);
    scl = 1'b1;
    tick(2);
    s = sda;
    scl = 1'b0;
  endtask
  // eight bits msb first, then the ack slot
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_slot(d[i], s);
      q[i] = s;
    end
    bit_slot(~mack, s);
    ack = ~s;
  endtask
endmodule

// [testbench/tb_optical_sensor_i2c_register_slave.sv]
// self-checking bench for the serial register port
`timescale 1ns/1ns
module tb_optical_sensor_i2c_register_slave;
  import optical_sensor_pkg::*;
  // arbitrary identifier value
  localparam logic [7:0] ID_VAL = 8'hA7;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sample_byte = 8'h40;
  logic pilot_use_green = 1'b0;
  logic scl, sda_pull, sda_out, sda_oe_n, int_n, sample_pop, ack;
  logic [7:0] amp, q, irfs;
  logic [1:0] rng;
  logic [9:0] pil;
  int err_count = 0;
  int comparisons = 0;
  int pops = 0;
  // open drain with pull-up
  wire sda = !(sda_pull || (!sda_oe_n && !sda_out));
  always #2 ref_clk = ~ref_clk;
  // queue stand-in advances on each pop, driven on the falling edge
  always @(negedge ref_clk)
  begin
    if (sample_pop)
    begin
      sample_byte <= sample_byte + 8'h01;
      pops <= pops + 1;
    end
  end
  optical_sensor_i2c_register_slave #(.DEVICE_ID_VALUE(ID_VAL)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .int_n(int_n), .sample_byte(sample_byte), .sample_pop(sample_pop),
    .pilot_use_green(pilot_use_green), .proximity_led_amplitude(amp),
    .ir_led_current_range(rng), .pilot_current(pil), .ir_full_scale_ma(irfs)
  );
  bus_master_model m_u (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  // ====================
  // tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] d[$]);
    m_u.start();
    m_u.xfer(WRITE_ADDR_BYTE, 1'b0, q, ack);
    check(ack, 1'b1);
    m_u.xfer(r, 1'b0, q, ack);
    check(ack, 1'b1);
    foreach (d[i])
    begin
      m_u.xfer(d[i], 1'b0, q, ack);
      check(ack, 1'b1);
    end
    m_u.stop();
  endtask
  task automatic rd(input logic [7:0] r, input logic [7:0] e[$]);
    m_u.start();
    m_u.xfer(WRITE_ADDR_BYTE, 1'b0, q, ack);
    m_u.xfer(r, 1'b0, q, ack);
    m_u.start();
    m_u.xfer(READ_ADDR_BYTE, 1'b0, q, ack);
    check(ack, 1'b1);
    foreach (e[i])
    begin
      m_u.xfer(8'hFF, i < e.size() - 1, q, ack);
      check(q, e[i]);
    end
    m_u.stop();
  endtask
  // ====================
  // sequence
  initial
  begin
    repeat (8) @(negedge ref_clk);
    check(int_n, 1'b1);
    reset = 1'b0;
    m_u.tick(4);
    check(int_n, 1'b0);
    check(amp, PROX_AMP_RESET);
    check(pil, 10'h000);
    check(irfs, 8'h32);
    // each wrong address bit is ignored, then retried below
    for (int b = 1; b < 8; b++)
    begin
      m_u.start();
      m_u.xfer(WRITE_ADDR_BYTE ^ (8'h01 << b), 1'b0, q, ack);
      check(ack, 1'b0);
      m_u.xfer(PROX_AMP_ADDR, 1'b0, q, ack);
      check(ack, 1'b0);
      m_u.stop();
    end
    wr(LED_RANGE_ADDR, '{8'h03, 8'h33, 8'h77});
    check(rng, 2'h3);
    check(amp, 8'h33);
    check(irfs, 8'hC8);
    check(pil, 10'h0CC);
    pilot_use_green = 1'b1;
    m_u.tick(4);
    check(pil, 10'h033);
    pilot_use_green = 1'b0;
    rd(LED_RANGE_ADDR, '{8'h03, 8'h33, 8'h00});
    check(int_n, 1'b0);
    rd(INT_STATUS_ADDR, '{8'h80});
    check(int_n, 1'b1);
    wr(DEVICE_ID_ADDR, '{8'h00});
    rd(DEVICE_ID_ADDR, '{ID_VAL, 8'h00});
    rd(SAMPLE_QUEUE_ADDR, '{8'h40, 8'h41, 8'h42});
    check(16'(pops), 16'h0003);
    // a stop before any data byte leaves the register alone
    m_u.start();
    m_u.xfer(WRITE_ADDR_BYTE, 1'b0, q, ack);
    m_u.xfer(PROX_AMP_ADDR, 1'b0, q, ack);
    m_u.stop();
    check(amp, 8'h33);
    m_u.start();
    m_u.xfer(READ_ADDR_BYTE, 1'b0, q, ack);
    m_u.xfer(8'hFF, 1'b0, q, ack);
    check(q, 8'h33);
    m_u.stop();
    give_verdict();
  end
  // whole run is near 16 us; about six times that means a hang
  initial
  begin
    #100000;
    err_count++;
    give_verdict();
  end
endmodule
